// *** logic/gpit_pkg.sv ***
// Shared constants and types of the 16-bit interval timer
package gpit_pkg;

   // ************************************************************
   // Register indices; the byte address is four times the index
   // ************************************************************
   localparam logic [9:0] IDX_COUNT = 10'h100; // Count value
   localparam logic [9:0] IDX_PERIOD = 10'h102; // Period value
   localparam logic [9:0] IDX_CONTROL = 10'h104; // Timer control word
   localparam logic [9:0] IDX_STATUS = 10'h106; // Sticky event flags
   localparam logic [9:0] IDX_CLEAR = 10'h107; // Write one to clear
   localparam logic [9:0] IDX_ENABLE = 10'h108; // Interrupt enables
   localparam int IDX_LSB = 2; // Lowest address bit of the index
   localparam int IDX_MSB = 11; // Highest address bit of the index

   // ************************************************************
   // Control word field positions
   // ************************************************************
   localparam int BIT_TIMER_ON = 15; // Timer on bit
   localparam int BIT_IDLE_STOP = 13; // Idle stop bit
   localparam int BIT_GATE_ACC = 6; // Gate accumulate enable
   localparam int BIT_PS_MSB = 5; // Prescale select, upper bit
   localparam int BIT_PS_LSB = 4; // Prescale select, lower bit
   localparam int BIT_EXT_SYNC = 2; // External sync select
   localparam int BIT_CLK_SRC = 1; // Clock source select

   // ************************************************************
   // Event flags and reset values
   // ************************************************************
   localparam int EV_MATCH = 0; // Period match flag
   localparam int EV_GATE = 1; // Gate falling edge flag
   localparam int EV_W = 2; // Number of event flags
   localparam logic [15:0] COUNT_RESET = 16'h0000; // Count after reset
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF; // Period after reset
   localparam logic [15:0] COUNT_STEP = 16'h0001; // Count increment

   // ************************************************************
   // Prescaler terminal phases (ratio minus one)
   // ************************************************************
   localparam logic [7:0] PS_LAST_DIV1 = 8'h00; // Divide by 1
   localparam logic [7:0] PS_LAST_DIV8 = 8'h07; // Divide by 8
   localparam logic [7:0] PS_LAST_DIV64 = 8'h3F; // Divide by 64
   localparam logic [7:0] PS_LAST_DIV256 = 8'hFF; // Divide by 256

   // ************************************************************
   // Bus constants
   // ************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // Single transfer
   localparam logic HRESP_OKAY = 1'h0; // Only response given

   // Prescale select encoding
   typedef enum logic [1:0] {
      PS_DIV1 = 2'b00,
      PS_DIV8 = 2'b01,
      PS_DIV64 = 2'b10,
      PS_DIV256 = 2'b11
   } gpit_ps_t;

   // Timer control word fields
   typedef struct packed {
      logic timerOn;
      logic idleStop;
      logic gateAcc;
      gpit_ps_t prescale;
      logic extSync;
      logic clkSrc;
   } gpit_ctrl_t;

   // Master side of the register bus
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } gpit_ahb_req_t;

   // Slave side of the register bus
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } gpit_ahb_rsp_t;

endpackage

// *** logic/gpit_sync2.sv ***
// Two flip-flop synchroniser for one level from outside the clock
module gpit_sync2 (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic asyncIn,
   output logic syncOut
);
   import gpit_pkg::*;

   // Both stages of the synchroniser
   typedef struct packed {
      logic stage1;
      logic stage2;
   } gpit_sync_t;

   gpit_sync_t st_reg; // Registered state
   gpit_sync_t st_next; // Next state

   // Shift the level through two stages
   always_comb begin
      st_next = st_reg;
      st_next.stage1 = asyncIn;
      st_next.stage2 = st_reg.stage1;
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign syncOut = st_reg.stage2;
endmodule

// *** logic/gpit_prescaler.sv ***
// Input clock prescaler with ratios 1, 8, 64 and 256
module gpit_prescaler #(
   parameter int CNT_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic inTick,
   input wire gpit_pkg::gpit_ps_t divSelect,
   output logic outTick
);
   import gpit_pkg::*;

   // Prescaler phase counter
   typedef struct packed {
      logic [CNT_W-1:0] phase;
   } gpit_psst_t;

   gpit_psst_t st_reg; // Registered state
   gpit_psst_t st_next; // Next state
   logic [CNT_W-1:0] lastPhase; // Phase that emits a tick

   // Decode the terminal phase of the ratio
   always_comb begin
      unique case (divSelect)
         PS_DIV1: lastPhase = CNT_W'(PS_LAST_DIV1);
         PS_DIV8: lastPhase = CNT_W'(PS_LAST_DIV8);
         PS_DIV64: lastPhase = CNT_W'(PS_LAST_DIV64);
         PS_DIV256: lastPhase = CNT_W'(PS_LAST_DIV256);
      endcase
   end

   // One output tick per ratio input ticks; a phase left past the end
   // by a ratio change ends the period at once instead of stalling
   assign outTick = inTick && (st_reg.phase >= lastPhase);

   // Count input ticks; a clear wins over a tick
   always_comb begin
      st_next = st_reg;
      if (clear) begin
         st_next.phase = '0;
      end else if (inTick) begin
         if (st_reg.phase >= lastPhase) begin
            st_next.phase = '0;
         end else begin
            st_next.phase = CNT_W'(st_reg.phase + 1'b1);
         end
      end
   end

   // State register, cleared by device reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// *** logic/gpit_timer.sv ***
// Top of the 16-bit interval timer with its register bus slave
//
// Function
// - Internal mode counts cycles, wraps at period
// - Synchronous mode counts synchronised external rising edges
// - Asynchronous mode counts external edges, wraps at period
// - Idle with idle stop set halts counting
// - Gated mode counts only while gate high
// - Gating needs gate bit, timer on, internal
// - Prescaler divides by 1, 8, 64, 256
// - Prescaler cleared by count write, disable, reset
// - Disabled timer leaves prescaler untouched
// - Control writes never change the count
// - Events on period match and gate fall
// - Sleep counting only in asynchronous external mode
module gpit_timer (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire gpit_pkg::gpit_ahb_req_t ahbReq,
   output gpit_pkg::gpit_ahb_rsp_t ahbRsp,
   input wire logic extClkGatePin,
   input wire logic cpuIdle,
   input wire logic cpuSleep,
   output logic irq
);
   import gpit_pkg::*;

   // ************************************************************
   // Types and state
   // ************************************************************

   // Phase of the bus slave
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } gpit_bus_t;

   // Whole state of the block
   typedef struct packed {
      gpit_bus_t busPhase;
      logic [9:0] addrIdx;
      logic readyOut;
      logic [31:0] rdata;
      logic [15:0] count;
      logic [15:0] period;
      gpit_ctrl_t ctrl;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] enable;
      logic irqOut;
      logic pinPrev;
   } gpit_state_t;

   gpit_state_t st_reg; // Registered state
   gpit_state_t st_next; // Next state

   logic pinSync; // Pin level after two flip-flops
   logic accept; // Address phase taken this cycle
   logic countWrite; // Data phase writes the count
   logic periodWrite; // Data phase writes the period
   logic ctrlWrite; // Data phase writes the control word
   logic clearWrite; // Data phase writes the clear mask
   logic enableWrite; // Data phase writes the enables
   logic gatedMode; // Gated accumulation is running
   logic asyncExt; // Asynchronous external counter selected
   logic halted; // Idle or sleep stops counting
   logic rawTick; // Selected input clock event
   logic psInTick; // Input event fed to the prescaler
   logic psClear; // Prescaler clear request
   logic psTick; // Prescaler output event
   logic matchEv; // Period match this cycle
   logic gateEv; // Gate falling edge this cycle
   logic [EV_W-1:0] clearMask; // Flags cleared by software
   logic [31:0] readValue; // Register selected for a read

   // ************************************************************
   // Pin synchroniser and prescaler
   // ************************************************************

   // Pin level is only read after the synchroniser
   gpit_sync2 u_pin_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .asyncIn(extClkGatePin),
      .syncOut(pinSync)
   );

   // Divider of the selected input clock
   gpit_prescaler #(
      .CNT_W(8)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(psClear),
      .inTick(psInTick),
      .divSelect(st_reg.ctrl.prescale),
      .outTick(psTick)
   );

   // ************************************************************
   // Bus decode
   // ************************************************************

   // Strobes of the data phase of a write
   always_comb begin
      accept = ahbReq.hsel && ahbReq.hready
               && (ahbReq.htrans == HTRANS_NONSEQ);
      countWrite = (st_reg.busPhase == BUS_WRITE)
                   && (st_reg.addrIdx == IDX_COUNT);
      periodWrite = (st_reg.busPhase == BUS_WRITE)
                    && (st_reg.addrIdx == IDX_PERIOD);
      ctrlWrite = (st_reg.busPhase == BUS_WRITE)
                  && (st_reg.addrIdx == IDX_CONTROL);
      clearWrite = (st_reg.busPhase == BUS_WRITE)
                   && (st_reg.addrIdx == IDX_CLEAR);
      enableWrite = (st_reg.busPhase == BUS_WRITE)
                    && (st_reg.addrIdx == IDX_ENABLE);
   end

   // Read multiplexer; unmapped and write-only words read zero
   always_comb begin
      readValue = '0;
      unique case (st_reg.addrIdx)
         IDX_COUNT: readValue[15:0] = st_reg.count;
         IDX_PERIOD: readValue[15:0] = st_reg.period;
         IDX_CONTROL: begin
            readValue[BIT_TIMER_ON] = st_reg.ctrl.timerOn;
            readValue[BIT_IDLE_STOP] = st_reg.ctrl.idleStop;
            readValue[BIT_GATE_ACC] = st_reg.ctrl.gateAcc;
            readValue[BIT_PS_MSB:BIT_PS_LSB] = st_reg.ctrl.prescale;
            readValue[BIT_EXT_SYNC] = st_reg.ctrl.extSync;
            readValue[BIT_CLK_SRC] = st_reg.ctrl.clkSrc;
         end
         IDX_STATUS: readValue[EV_W-1:0] = st_reg.status;
         IDX_ENABLE: readValue[EV_W-1:0] = st_reg.enable;
         default: readValue = '0;
      endcase
   end

   // ************************************************************
   // Timer datapath
   // ************************************************************

   // Mode decode and input event selection
   always_comb begin
      // Gating only with internal clock and timer on
      gatedMode = st_reg.ctrl.timerOn && st_reg.ctrl.gateAcc
                  && !st_reg.ctrl.clkSrc;
      asyncExt = st_reg.ctrl.clkSrc && !st_reg.ctrl.extSync;
      // Idle stop and sleep conditions
      halted = (cpuIdle && st_reg.ctrl.idleStop)
               || (cpuSleep && !(st_reg.ctrl.timerOn
                                 && asyncExt));
      if (st_reg.ctrl.clkSrc) begin
         // External rising edge, sync or async
         rawTick = pinSync && !st_reg.pinPrev;
      end else if (gatedMode) begin
         rawTick = pinSync;
      end else begin
         rawTick = 1'b1;
      end
      // A stopped timer feeds nothing to the prescaler
      psInTick = st_reg.ctrl.timerOn && !halted
                 && rawTick;
      // Clear on count write or when the on bit falls
      psClear = countWrite || (ctrlWrite && st_reg.ctrl.timerOn
                && !ahbReq.hwdata[BIT_TIMER_ON]);
      matchEv = psTick && (st_reg.count == st_reg.period);
      gateEv = gatedMode && st_reg.pinPrev
               && !pinSync;
      clearMask = clearWrite ? ahbReq.hwdata[EV_W-1:0] : '0;
   end

   // ************************************************************
   // Next state
   // ************************************************************

   // Whole next state of bus slave, timer and flags
   always_comb begin
      st_next = st_reg;
      st_next.pinPrev = pinSync;
      // Count: a direct write wins over counting
      if (countWrite) begin
         st_next.count = ahbReq.hwdata[15:0];
      end else if (matchEv) begin
         st_next.count = COUNT_RESET;
      end else if (psTick) begin
         st_next.count = 16'(st_reg.count + COUNT_STEP);
      end
      // Period and control word writes
      if (periodWrite) begin
         st_next.period = ahbReq.hwdata[15:0];
      end
      if (ctrlWrite) begin
         // Only control fields change, never the count
         st_next.ctrl.timerOn = ahbReq.hwdata[BIT_TIMER_ON];
         st_next.ctrl.idleStop = ahbReq.hwdata[BIT_IDLE_STOP];
         st_next.ctrl.gateAcc = ahbReq.hwdata[BIT_GATE_ACC];
         st_next.ctrl.prescale =
            gpit_ps_t'(ahbReq.hwdata[BIT_PS_MSB:BIT_PS_LSB]);
         st_next.ctrl.extSync = ahbReq.hwdata[BIT_EXT_SYNC];
         st_next.ctrl.clkSrc = ahbReq.hwdata[BIT_CLK_SRC];
      end
      if (enableWrite) begin
         st_next.enable = ahbReq.hwdata[EV_W-1:0];
      end
      // Sticky flags: a new event wins over a clear
      st_next.status = (st_reg.status & ~clearMask)
                       | {gateEv, matchEv};
      st_next.irqOut = |(st_next.status & st_next.enable);
      // Bus slave phases
      unique case (st_reg.busPhase)
         BUS_IDLE, BUS_WRITE: begin
            st_next.busPhase = BUS_IDLE;
            st_next.readyOut = 1'b1;
            if (accept) begin
               st_next.addrIdx = ahbReq.haddr[IDX_MSB:IDX_LSB];
               if (ahbReq.hwrite) begin
                  st_next.busPhase = BUS_WRITE;
               end else begin
                  // One wait state to fetch the word
                  st_next.busPhase = BUS_READ;
                  st_next.readyOut = 1'b0;
               end
            end
         end
         BUS_READ: begin
            // Data stands with ready high
            st_next.rdata = readValue;
            st_next.readyOut = 1'b1;
            st_next.busPhase = BUS_IDLE;
         end
         default: begin
            st_next.busPhase = BUS_IDLE;
            st_next.readyOut = 1'b1;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Every field takes a constant at reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.busPhase <= BUS_IDLE;
         st_reg.readyOut <= 1'b1;
         st_reg.count <= COUNT_RESET;
         st_reg.period <= PERIOD_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops; hresp is tied to OKAY
   assign ahbRsp.hreadyout = st_reg.readyOut;
   assign ahbRsp.hresp = HRESP_OKAY;
   assign ahbRsp.hrdata = st_reg.rdata;
   assign irq = st_reg.irqOut;

   // ************************************************************
   // Assertions
   // ************************************************************

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Match returns the count to zero
   a_wrap_to_zero:
   assert property (matchEv && !countWrite |=> st_reg.count == 16'h0000)
      else $error("count did not wrap to zero on match");

   // Internal divide-by-one counts every cycle
   a_internal_step:
   assert property (st_reg.ctrl.timerOn && !st_reg.ctrl.clkSrc
      && !st_reg.ctrl.gateAcc && st_reg.ctrl.prescale == PS_DIV1
      && !cpuIdle && !cpuSleep && !countWrite && !ctrlWrite
      && st_reg.count != st_reg.period
      |=> st_reg.count == 16'($past(st_reg.count) + COUNT_STEP))
      else $error("internal count did not step by one");

   // Idle stop freezes the count
   a_idle_hold:
   assert property (st_reg.ctrl.idleStop && cpuIdle && !countWrite
      |=> $stable(st_reg.count))
      else $error("count moved while idle stopped");

   // Disabled timer keeps its count
   a_off_hold:
   assert property (!st_reg.ctrl.timerOn && !countWrite
      |=> $stable(st_reg.count))
      else $error("count moved while timer off");

   // Low gate freezes a gated count
   a_gate_low_hold:
   assert property (gatedMode && !pinSync && !countWrite
      |=> $stable(st_reg.count))
      else $error("gated count moved with gate low");

   // Sleep stops all but the asynchronous counter
   a_sleep_hold:
   assert property (cpuSleep && !asyncExt && !countWrite
      |=> $stable(st_reg.count))
      else $error("count moved in sleep");

   // Match sets its sticky flag, which holds the next cycle unless cleared
   a_match_flag:
   assert property (matchEv |=> st_reg.status[EV_MATCH]
      ##1 (st_reg.status[EV_MATCH] || $past(clearWrite)))
      else $error("match flag not set or lost");

   // Enabled pending flag drives the interrupt
   a_irq_level:
   assert property ((st_reg.status & st_reg.enable) != '0 |-> irq)
      else $error("interrupt low with enabled flag set");

   // A read answers after exactly one wait state
   a_read_wait:
   assert property (accept && !ahbReq.hwrite
      |=> !ahbRsp.hreadyout ##1 ahbRsp.hreadyout)
      else $error("read did not answer after one wait state");

   // Control writes never touch the count
   a_ctrl_keeps_count:
   assert property (ctrlWrite && !psTick |=> $stable(st_reg.count))
      else $error("control write changed the count");

   // Count writes load the written value
   a_count_load:
   assert property (countWrite
      |=> st_reg.count == $past(ahbReq.hwdata[15:0]))
      else $error("count write did not load the value");

   // Gate fall sets its sticky flag
   a_gate_flag:
   assert property (gateEv |=> st_reg.status[EV_GATE])
      else $error("gate fall flag not set");

endmodule

// *** testbench/gpit_ext_source.sv ***
// External clock and gate source model for the interval timer
module gpit_ext_source (
   input wire logic ref_clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pin stands low outside bursts and windows
   initial pin = 1'b0;

   // Burst of n rising edges, h cycles per half period
   task automatic pulses(input int n, input int h);
      repeat (n) begin
         pin <= 1'b1;
         repeat (h) @(posedge ref_clk);
         pin <= 1'b0;
         repeat (h) @(posedge ref_clk);
      end
   endtask

   // Gate window held high for g cycles, then low
   task automatic gate(input int g);
      if (g > 0) begin
         pin <= 1'b1;
         repeat (g) @(posedge ref_clk);
         pin <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
endmodule

// *** testbench/gpit_timer_tb_top.sv ***
// Self-checking testbench of the 16-bit interval timer
module gpit_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gpit_pkg::*;

   // ********
   // Signals
   // ********
   localparam int LIMIT = 20000; // Cycle ceiling of the run
   localparam logic [15:0] C_ON = 16'h8000; // Timer on
   localparam logic [15:0] C_IDL = 16'h2000; // Idle stop
   localparam logic [15:0] C_GATE = 16'h0040; // Gate accumulate
   localparam logic [15:0] C_SYNC = 16'h0004; // External sync
   localparam logic [15:0] C_SRC = 16'h0002; // External source
   logic ref_clk; // System clock
   logic rst_n; // Active low reset
   gpit_ahb_req_t busReq; // Master drive
   gpit_ahb_req_t busIn; // Drive with hready looped back
   gpit_ahb_rsp_t busRsp; // Slave answer
   logic extPin; // Pin from the source model
   logic cpuIdle; // CPU idle level
   logic cpuSleep; // CPU sleep level
   logic irq; // Interrupt level
   int errorCnt; // Mismatches
   int checkCount; // Comparisons
   int cycCnt = 0; // Cycles run

   // Single slave: its hreadyout is the bus hready
   always_comb begin
      busIn = busReq;
      busIn.hready = busRsp.hreadyout;
   end

   gpit_timer i_dut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ahbReq(busIn),
      .ahbRsp(busRsp),
      .extClkGatePin(extPin),
      .cpuIdle(cpuIdle),
      .cpuSleep(cpuSleep),
      .irq(irq)
   );

   gpit_ext_source i_src (
      .ref_clk(ref_clk),
      .pin(extPin)
   );

   // Clock of 5 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cycCnt <= cycCnt + 1;
      if (cycCnt == LIMIT) begin
         errorCnt++;
         results();
      end
   end

   // ********
   // Tasks
   // ********
   // Verdict and end of run
   task automatic results();
      if (errorCnt == 0 && checkCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single AHB-Lite transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      busReq.hsel <= 1'b1;
      busReq.htrans <= HTRANS_NONSEQ;
      busReq.haddr <= {20'h00000, idx, 2'b00};
      busReq.hwrite <= w;
      do @(posedge ref_clk); while (busRsp.hreadyout !== 1'b1);
      busReq.hsel <= 1'b0;
      busReq.htrans <= 2'h0;
      busReq.hwdata <= wd;
      do @(posedge ref_clk); while (busRsp.hreadyout !== 1'b1);
      rd = busRsp.hrdata;
   endtask

   // Register write
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask

   // Register read and compare
   task automatic rdc(input logic [9:0] idx, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, idx, 32'h0, v);
      chk(v, e);
   endtask

   // Clear count, run with control c, stop, read the count
   task automatic run(input logic [15:0] c, input int cyc, input int np,
                      input int gl, output logic [31:0] cnt);
      wr(IDX_COUNT, 32'h0);
      wr(IDX_CONTROL, {16'h0000, c});
      i_src.pulses(np, 3);
      i_src.gate(gl);
      repeat (cyc) @(posedge ref_clk);
      wr(IDX_CONTROL, {16'h0000, c & 16'h7FFF});
      bus(1'b0, IDX_COUNT, 32'h0, cnt);
   endtask

   // ********
   // Scenarios
   // ********
   // Reset values, unused bits, unmapped place
   task automatic t_regs();
      rdc(IDX_COUNT, 32'h0);
      rdc(IDX_PERIOD, 32'h0000FFFF);
      rdc(IDX_CONTROL, 32'h0);
      rdc(IDX_STATUS, 32'h0);
      rdc(IDX_ENABLE, 32'h0);
      wr(10'h3FF, 32'hFFFFFFFF);
      chk({31'h0, busRsp.hresp}, {31'h0, HRESP_OKAY});
      rdc(10'h3FF, 32'h0);
      rdc(IDX_CLEAR, 32'h0);
      wr(IDX_ENABLE, 32'h3);
      rdc(IDX_ENABLE, 32'h3);
   endtask

   // Control write and pin activity while off leave the count
   task automatic t_hold();
      wr(IDX_COUNT, 32'h1234);
      wr(IDX_CONTROL, 32'h7FFF);
      rdc(IDX_CONTROL, 32'h2076);
      i_src.pulses(3, 3);
      i_src.gate(5);
      rdc(IDX_COUNT, 32'h1234);
      wr(IDX_CONTROL, 32'h0);
   endtask

   // Every ratio: extra 4 ratio-lengths give exactly 4 counts
   task automatic t_prescale();
      logic [31:0] a, b;
      logic [15:0] ps;
      int r;
      for (int i = 0; i < 4; i++) begin
         ps = 16'(i) << 4;
         r = (i == 3) ? 256 : 1 << (3 * i);
         run(C_ON | ps, 20, 0, 0, a);
         run(C_ON | ps, 20 + 4 * r, 0, 0, b);
         chk(b - a, 32'h4);
      end
   endtask

   // Wrap at period 5, match flag, masking and clearing
   task automatic t_wrap();
      logic [31:0] a, b;
      wr(IDX_ENABLE, 32'h0);
      wr(IDX_PERIOD, 32'h5);
      run(C_ON, 20, 0, 0, a);
      chk(a, 32'h4);
      run(C_ON, 26, 0, 0, b);
      chk(b, a);
      rdc(IDX_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_ENABLE, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_CLEAR, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      rdc(IDX_STATUS, 32'h0);
      wr(IDX_PERIOD, 32'h0000FFFF);
   endtask

   // Idle halts only with the idle stop bit
   task automatic t_idle();
      logic [31:0] a, b;
      run(C_ON, 20, 0, 0, a);
      chk(a, 32'h16);
      cpuIdle <= 1'b1;
      run(C_ON, 20, 0, 0, b);
      chk(b, a);
      run(C_ON | C_IDL, 20, 0, 0, b);
      chk(b, 32'h0);
      run(C_ON | C_IDL | C_SRC, 8, 4, 0, b);
      chk(b, 32'h0);
      cpuIdle <= 1'b0;
   endtask

   // External edges in both modes, and during sleep
   task automatic t_ext();
      logic [31:0] v;
      run(C_ON | C_SRC, 8, 7, 0, v);
      chk(v, 32'h7);
      run(C_ON | C_SRC | C_SYNC, 8, 7, 0, v);
      chk(v, 32'h7);
      run(C_ON | C_SRC | 16'h0010, 8, 16, 0, v);
      chk(v, 32'h2);
      cpuSleep <= 1'b1;
      run(C_ON | C_SRC, 8, 5, 0, v);
      chk(v, 32'h5);
      run(C_ON | C_SRC | C_SYNC, 8, 5, 0, v);
      chk(v, 32'h0);
      run(C_ON, 20, 0, 0, v);
      chk(v, 32'h0);
      cpuSleep <= 1'b0;
   endtask

   // Gated accumulation, gate fall event, gate ignored for source 1
   task automatic t_gate();
      logic [31:0] v;
      wr(IDX_CLEAR, 32'h3);
      wr(IDX_ENABLE, 32'h2);
      run(C_ON | C_GATE, 6, 0, 9, v);
      chk(v, 32'h9);
      rdc(IDX_STATUS, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_CLEAR, 32'h2);
      run(C_ON | C_GATE | C_SRC, 6, 0, 9, v);
      chk(v, 32'h1);
      rdc(IDX_STATUS, 32'h0);
   endtask

   // Main sequence
   initial begin
      busReq = '0;
      busReq.hsize = 3'h2;
      cpuIdle = 1'b0;
      cpuSleep = 1'b0;
      rst_n = 1'b0;
      errorCnt = 0;
      checkCount = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_hold();
      t_prescale();
      t_wrap();
      t_idle();
      t_ext();
      t_gate();
      results();
   end
endmodule
